/* stch_pkg.sv */
package stch_pkg;

  // command codes carried in the low nibble of a command word
  localparam logic [3:0] STCH_CMD_DISABLE = 4'hc;
  localparam logic [3:0] STCH_CMD_ENABLE = 4'hd;
  localparam logic [3:0] STCH_GLOBAL_ADDR = 4'h0;

  // register byte offsets
  localparam logic [11:0] STCH_OFS_CFG = 12'h000;
  localparam logic [11:0] STCH_OFS_FMT = 12'h004;
  localparam logic [11:0] STCH_OFS_STAT = 12'h008;
  localparam logic [11:0] STCH_OFS_RESP = 12'h00c;

  // configuration register fields
  localparam int STCH_CFG_ADDR_LSB = 0;
  localparam int STCH_CFG_ATTR_LSB = 4;
  localparam logic [3:0] STCH_CFG_ADDR_RST = 4'h0;
  localparam logic [1:0] STCH_CFG_ATTR_RST = 2'h0;

  // format selection values
  localparam logic [3:0] STCH_FMT_STANDARD = 4'h0;
  localparam logic [3:0] STCH_FMT_PROGRAMMED = 4'hf;
  localparam logic [3:0] STCH_FMT_RST = 4'h0;

  // status register bit positions
  localparam int STCH_STAT_DRIVE = 0;
  localparam int STCH_STAT_LOCK = 1;
  localparam int STCH_STAT_LASTDIS = 2;
  localparam int STCH_STAT_HOLD_CAPACITOR_PIN = 3;
  localparam int STCH_STAT_ERR = 4;
  localparam int STCH_STAT_OTP = 5;
  localparam int STCH_STAT_FMTPRG = 6;

  // response word bit positions: status byte, then the long answer's address field
  localparam int STCH_RSP_ERR = 1;
  localparam int STCH_RSP_ATTR_LSB = 2;
  localparam int STCH_RSP_ST = 5;
  localparam int STCH_RSP_HOLD_CAPACITOR_PIN = 6;
  localparam int STCH_RSP_OTP = 7;
  localparam int STCH_RSP_ADDR_LSB = 12;

  function automatic logic stch_word_hit(input logic [11:0] addr, input logic [11:0] ofs);
    stch_word_hit = (addr[11:2] == ofs[11:2]);
  endfunction

endpackage

/* stch_cmd_match.sv */
`timescale 1ns/1ns
module stch_cmd_match
  import stch_pkg::*;
(
  // decoded command
  input wire logic cmd_valid,
  input wire logic cmd_crc_ok,
  input wire logic [3:0] cmd_code,
  input wire logic [3:0] cmd_addr,
  // programmed bus address
  input wire logic [3:0] dev_addr,
  // actions
  output logic dis_act,
  output logic dis_respond,
  output logic en_act,
  output logic other_act
);

  logic accepted;
  logic addr_ok;
  logic global_addr;

  // a failed crc leaves every action dead
  assign accepted = cmd_valid & cmd_crc_ok;
  assign addr_ok = (cmd_addr == dev_addr);
  assign global_addr = (cmd_addr == STCH_GLOBAL_ADDR);

  // disable also acts on the global address, silently
  assign dis_act = accepted & (cmd_code == STCH_CMD_DISABLE) & (addr_ok | global_addr);
  assign dis_respond = dis_act & addr_ok & ~global_addr;
  // enable on the global address is dropped entirely
  assign en_act = accepted & (cmd_code == STCH_CMD_ENABLE) & addr_ok & ~global_addr;
  // any other addressed command breaks a disable pair
  assign other_act = accepted & addr_ok & ~global_addr & (cmd_code != STCH_CMD_DISABLE)
                     & (cmd_code != STCH_CMD_ENABLE);

endmodule

/* stch_resp_fmt.sv */
`timescale 1ns/1ns
module stch_resp_fmt
  import stch_pkg::*;
(
  // status sources
  input wire logic [3:0] dev_addr,
  input wire logic otp_flag,
  input wire logic hold_capacitor_pin_flag,
  input wire logic st_flag,
  input wire logic [1:0] attr,
  input wire logic err_flag,
  // formatted words
  output logic [14:0] short_word,
  output logic [15:0] long_word
);

  always_comb
  begin
    short_word = 15'h0000;
    short_word[STCH_RSP_OTP] = otp_flag;
    short_word[STCH_RSP_HOLD_CAPACITOR_PIN] = hold_capacitor_pin_flag;
    short_word[STCH_RSP_ST] = st_flag;
    short_word[STCH_RSP_ATTR_LSB +: 2] = attr;
    short_word[STCH_RSP_ERR] = err_flag;
    long_word = {1'b0, short_word};
    long_word[STCH_RSP_ADDR_LSB +: 4] = dev_addr;
  end

endmodule

/* stch_selftest_handler.sv */
`timescale 1ns/1ns
// Summary of operation
// - disable accepted in all four command formats
// - command data bits feed crc only
// - global disable acts but sends no answer
// - disable identified by code 1100 plus address
// - mismatched address ignored, no answer
// - valid disable removes self-test plate drive
// - short answer layout, unused bits zero
// - long answer: address, zeros, status byte
// - error flag mirrors detected internal error
// - self-test flag follows active circuitry
// - otp flag shows otp programming enable
// - hold-cap flag set when voltage low
// - attribute bits copied from config register
// - two disables in a row set lockout
// - lockout ends on hold_capacitor_pin low, clear, reset
// - enable accepted in all four formats
// - global enable fully ignored
// - enable identified by code 1101
// - enable applies drive until a disable
// - lockout keeps drive off, flag clear
// - format select 0000 standard, 1111 programmed
module stch_selftest_handler
  import stch_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // decoded bus command
  input wire logic cmd_valid,
  input wire logic cmd_long,
  input wire logic [3:0] cmd_code,
  input wire logic [3:0] cmd_addr,
  input wire logic cmd_crc_ok,
  // device events and levels
  input wire logic clear_cmd,
  input wire logic hold_capacitor_pin_low,
  input wire logic internal_error,
  input wire logic otp_program_enabled_flag,
  // self-test and format control
  output logic selftest_plate_drive,
  output logic selftest_lockout,
  output logic fmt_programmed,
  // response to the bus
  output logic resp_valid,
  output logic resp_long,
  output logic [15:0] resp_data
);

  typedef struct packed {
    logic [3:0] dev_addr;
    logic [1:0] attribute_bits;
    logic [3:0] fmt_sel;
    logic st_drive;
    logic lockout;
    logic last_was_dis;
    logic resp_valid;
    logic resp_long;
    logic [15:0] resp_data;
    logic [15:0] last_resp;
    logic [31:0] prdata;
  } stch_state_t;

  stch_state_t st_reg;
  stch_state_t st_next;

  logic dis_act;
  logic dis_respond;
  logic en_act;
  logic other_act;
  logic [14:0] short_word;
  logic [15:0] long_word;
  logic st_after;
  logic lock_after;
  logic [11:0] addr12;
  logic setup_phase;
  logic access_phase;
  logic hit_cfg;
  logic hit_fmt;
  logic hit_stat;
  logic hit_resp;
  logic hit_any;
  logic wr_en;
  logic [31:0] stat_word;

  // command data never reaches this block; the crc engine consumes it
  stch_cmd_match u_match (
    .cmd_valid(cmd_valid),
    .cmd_crc_ok(cmd_crc_ok),
    .cmd_code(cmd_code),
    .cmd_addr(cmd_addr),
    .dev_addr(st_reg.dev_addr),
    .dis_act(dis_act),
    .dis_respond(dis_respond),
    .en_act(en_act),
    .other_act(other_act)
  );

  // answer carries the state as it stands after the command
  stch_resp_fmt u_fmt (
    .dev_addr(st_reg.dev_addr),
    .otp_flag(otp_program_enabled_flag),
    .hold_capacitor_pin_flag(hold_capacitor_pin_low),
    .st_flag(st_after),
    .attr(st_reg.attribute_bits),
    .err_flag(internal_error),
    .short_word(short_word),
    .long_word(long_word)
  );

  // lockout and drive after this cycle's events
  always_comb
  begin
    lock_after = st_reg.lockout;
    // release first so a new second disable still wins
    if (clear_cmd || hold_capacitor_pin_low)
    begin
      lock_after = 1'b0;
    end
    if (dis_act && st_reg.last_was_dis)
    begin
      lock_after = 1'b1;
    end
    st_after = st_reg.st_drive;
    if (en_act && !lock_after)
    begin
      st_after = 1'b1;
    end
    if (dis_act || lock_after)
    begin
      st_after = 1'b0;
    end
  end

  // apb decode
  assign addr12 = 12'(paddr);
  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  assign hit_cfg = stch_word_hit(addr12, STCH_OFS_CFG);
  assign hit_fmt = stch_word_hit(addr12, STCH_OFS_FMT);
  assign hit_stat = stch_word_hit(addr12, STCH_OFS_STAT);
  assign hit_resp = stch_word_hit(addr12, STCH_OFS_RESP);
  assign hit_any = hit_cfg | hit_fmt | hit_stat | hit_resp;
  // zero wait states: the read word was loaded during setup
  assign pready = access_phase;
  assign pslverr = access_phase & ~hit_any;
  // writes land at the single edge that completes the access
  assign wr_en = access_phase & pwrite & pstrb[0];

  always_comb
  begin
    stat_word = 32'h0000_0000;
    stat_word[STCH_STAT_DRIVE] = st_reg.st_drive;
    stat_word[STCH_STAT_LOCK] = st_reg.lockout;
    stat_word[STCH_STAT_LASTDIS] = st_reg.last_was_dis;
    stat_word[STCH_STAT_HOLD_CAPACITOR_PIN] = hold_capacitor_pin_low;
    stat_word[STCH_STAT_ERR] = internal_error;
    stat_word[STCH_STAT_OTP] = otp_program_enabled_flag;
    stat_word[STCH_STAT_FMTPRG] = (st_reg.fmt_sel == STCH_FMT_PROGRAMMED);
  end

  always_comb
  begin
    st_next = st_reg;
    st_next.resp_valid = 1'b0;

    // software side
    if (wr_en && hit_cfg)
    begin
      st_next.dev_addr = pwdata[STCH_CFG_ADDR_LSB +: 4];
      st_next.attribute_bits = pwdata[STCH_CFG_ATTR_LSB +: 2];
    end
    if (wr_en && hit_fmt)
    begin
      // only the two defined selections are taken; others keep the old value
      if (pwdata[3:0] == STCH_FMT_STANDARD || pwdata[3:0] == STCH_FMT_PROGRAMMED)
      begin
        st_next.fmt_sel = pwdata[3:0];
      end
    end
    if (setup_phase)
    begin
      st_next.prdata = 32'h0000_0000;
      if (hit_cfg)
      begin
        st_next.prdata[STCH_CFG_ADDR_LSB +: 4] = st_reg.dev_addr;
        st_next.prdata[STCH_CFG_ATTR_LSB +: 2] = st_reg.attribute_bits;
      end
      else if (hit_fmt)
      begin
        st_next.prdata[3:0] = st_reg.fmt_sel;
      end
      else if (hit_stat)
      begin
        st_next.prdata = stat_word;
      end
      else if (hit_resp)
      begin
        st_next.prdata[15:0] = st_reg.last_resp;
      end
    end

    // bus command side; format is not filtered, all four pass
    st_next.lockout = lock_after;
    st_next.st_drive = st_after;
    if (dis_act)
    begin
      st_next.last_was_dis = 1'b1;
    end
    else if (en_act || other_act)
    begin
      st_next.last_was_dis = 1'b0;
    end

    if (dis_respond || en_act)
    begin
      st_next.resp_valid = 1'b1;
      st_next.resp_long = cmd_long;
      if (cmd_long)
      begin
        st_next.resp_data = long_word;
      end
      else
      begin
        st_next.resp_data = {1'b0, short_word};
      end
      st_next.last_resp = st_next.resp_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg.dev_addr <= STCH_CFG_ADDR_RST;
      st_reg.attribute_bits <= STCH_CFG_ATTR_RST;
      st_reg.fmt_sel <= STCH_FMT_RST;
      st_reg.st_drive <= 1'b0;
      // reset from any cause clears the lockout
      st_reg.lockout <= 1'b0;
      st_reg.last_was_dis <= 1'b0;
      st_reg.resp_valid <= 1'b0;
      st_reg.resp_long <= 1'b0;
      st_reg.resp_data <= 16'h0000;
      st_reg.last_resp <= 16'h0000;
      st_reg.prdata <= 32'h0000_0000;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign prdata = st_reg.prdata;
  assign selftest_plate_drive = st_reg.st_drive;
  assign selftest_lockout = st_reg.lockout;
  assign fmt_programmed = (st_reg.fmt_sel == STCH_FMT_PROGRAMMED);
  assign resp_valid = st_reg.resp_valid;
  assign resp_long = st_reg.resp_long;
  assign resp_data = st_reg.resp_data;

endmodule

/* stch_dsi_master.sv */
`timescale 1ns/1ns
module stch_dsi_master
  import stch_pkg::*;
(
  // clock
  input wire logic pclk,
  // command port
  output logic cmd_valid,
  output logic cmd_long,
  output logic [3:0] cmd_code,
  output logic [3:0] cmd_addr,
  output logic cmd_crc_ok
);
  initial
  begin
    cmd_valid = 1'b0;
    cmd_long = 1'b0;
    cmd_code = 4'h0;
    cmd_addr = 4'h0;
    cmd_crc_ok = 1'b0;
  end
  // every call drives all five fields, so stale values never pass for a frame
  task automatic send(input logic v, l, input logic [3:0] c, a, input logic ok);
    cmd_valid <= v;
    cmd_long <= l;
    cmd_code <= c;
    cmd_addr <= a;
    cmd_crc_ok <= ok;
  endtask
endmodule

/* stch_selftest_handler_sva.sv */
`timescale 1ns/1ns
module stch_chk
  import stch_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // command and levels
  input wire logic cmd_valid,
  input wire logic cmd_long,
  input wire logic [3:0] cmd_code,
  input wire logic [3:0] cmd_addr,
  input wire logic cmd_crc_ok,
  input wire logic clear_cmd,
  input wire logic hold_capacitor_pin_low,
  input wire logic internal_error,
  input wire logic otp_program_enabled_flag,
  // outputs
  input wire logic selftest_plate_drive,
  input wire logic selftest_lockout,
  input wire logic resp_valid,
  input wire logic resp_long,
  input wire logic [15:0] resp_data
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_ok;
    cmd_valid && cmd_crc_ok;
  endsequence
  sequence s_gdis;
    s_ok ##0 cmd_code == STCH_CMD_DISABLE && cmd_addr == STCH_GLOBAL_ADDR;
  endsequence
  a_resp_cause: assert property (resp_valid |-> $past(cmd_valid && cmd_crc_ok && cmd_addr != 4'h0
    && (cmd_code == STCH_CMD_DISABLE || cmd_code == STCH_CMD_ENABLE)))
    else $error("answer without a valid self-test command");
  a_global_quiet: assert property (s_ok ##0 cmd_addr == STCH_GLOBAL_ADDR |=> !resp_valid)
    else $error("answer to global address");
  a_global_dis: assert property (s_gdis |=> !selftest_plate_drive)
    else $error("global disable left drive on");
  a_pair_lock: assert property (s_gdis ##1 s_gdis |=> selftest_lockout)
    else $error("two disables gave no lockout");
  a_short_form: assert property (resp_valid && !resp_long |->
    resp_data[15:8] == 8'h00 && !resp_data[4] && !resp_data[0])
    else $error("short answer layout");
  a_long_form: assert property (resp_valid && resp_long |-> resp_data[11:8] == 4'h0
    && !resp_data[4] && !resp_data[0] && resp_data[15:12] == $past(cmd_addr))
    else $error("long answer layout");
  a_resp_kind: assert property (resp_valid |-> resp_long == $past(cmd_long))
    else $error("answer length differs from command");
  a_status_bits: assert property (resp_valid |-> {resp_data[7], resp_data[6], resp_data[1]} ==
    $past({otp_program_enabled_flag, hold_capacitor_pin_low, internal_error}))
    else $error("status flags wrong");
  a_st_state: assert property (resp_valid |-> resp_data[5] == selftest_plate_drive)
    else $error("self-test flag differs from drive");
  a_en_drive: assert property (resp_valid && $past(cmd_code) == STCH_CMD_ENABLE |->
    selftest_plate_drive != selftest_lockout)
    else $error("enable drive wrong");
  a_lock_off: assert property (selftest_lockout |-> !selftest_plate_drive)
    else $error("drive on under lockout");
  a_crc_keep: assert property (cmd_valid && !cmd_crc_ok && !clear_cmd && !hold_capacitor_pin_low
    |=> $stable(selftest_plate_drive) && $stable(selftest_lockout))
    else $error("bad crc changed state");
  a_lock_free: assert property (selftest_lockout && !cmd_valid
    && (clear_cmd || hold_capacitor_pin_low) |=> !selftest_lockout)
    else $error("lockout not released");
endmodule
bind stch_selftest_handler stch_chk chk_u (.pclk, .presetn, .cmd_valid, .cmd_long, .cmd_code,
  .cmd_addr, .cmd_crc_ok, .clear_cmd, .hold_capacitor_pin_low, .internal_error,
  .otp_program_enabled_flag, .selftest_plate_drive, .selftest_lockout, .resp_valid,
  .resp_long, .resp_data);

/* stch_selftest_handler_tb.sv */
`timescale 1ns/1ns
module stch_selftest_handler_tb
  import stch_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, c, a;
  logic cmd_valid, cmd_long, cmd_crc_ok, clear_cmd, hold_capacitor_pin_low;
  logic internal_error, otp_program_enabled_flag, v, l, ok, cl, hc, ie, ot;
  logic [3:0] cmd_code, cmd_addr;
  logic selftest_plate_drive, selftest_lockout, fmt_programmed, resp_valid, resp_long;
  logic [15:0] resp_data, e_rd, e_last;
  logic e_rv, e_rl;
  int n_errors, checks_done, dev, attr, m_drv, m_lock, m_last, k;
  logic [3:0] fv[3] = '{4'hf, 4'h5, 4'h0};
  logic fe[3] = '{1'b1, 1'b1, 1'b0};
  stch_selftest_handler #(.ADDR_W(12)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .cmd_valid, .cmd_long, .cmd_code,
    .cmd_addr, .cmd_crc_ok, .clear_cmd, .hold_capacitor_pin_low, .internal_error,
    .otp_program_enabled_flag, .selftest_plate_drive, .selftest_lockout, .fmt_programmed,
    .resp_valid, .resp_long, .resp_data);
  stch_dsi_master mst_u (.pclk, .cmd_valid, .cmd_long, .cmd_code, .cmd_addr, .cmd_crc_ok);
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // idle edge at the end keeps psel to one assignment per time step
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic model();
    logic hit, set;
    hit = v && ok && a == dev[3:0];
    set = 1'b0;
    e_rv = hit && (c == STCH_CMD_DISABLE || c == STCH_CMD_ENABLE);
    if (v && ok && c == STCH_CMD_DISABLE && (hit || a == STCH_GLOBAL_ADDR))
    begin
      m_drv = 0;
      set = m_last[0];
      m_lock = m_lock | m_last;
      m_last = 1;
    end
    else if (hit)
    begin
      if (c == STCH_CMD_ENABLE)
        m_drv = !m_lock;
      m_last = 0;
    end
    if ((cl || hc) && !set)
      m_lock = 0;
    e_rd = {ot, hc, m_drv[0], 1'b0, attr[1:0], ie, 1'b0};
    if (l)
      e_rd[15:12] = dev[3:0];
    e_rl = l;
    // the answer register keeps the last word that went out
    if (e_rv)
      e_last = e_rd;
  endtask
  task automatic check_out();
    chk("resp_valid", resp_valid, e_rv);
    if (e_rv)
    begin
      chk("resp_data", resp_data, e_rd);
      chk("resp_long", resp_long, e_rl);
    end
    chk("drive", selftest_plate_drive, m_drv);
    chk("lockout", selftest_lockout, m_lock);
  endtask
  initial
  begin
    {presetn, psel, penable, pwrite, clear_cmd, hold_capacitor_pin_low} = 6'h00;
    {internal_error, otp_program_enabled_flag, e_rv} = 3'h0;
    e_last = 16'h0000;
    {paddr, pwdata, pstrb} = {12'h000, 32'h0, 4'hf};
    {n_errors, checks_done, m_drv, m_lock, m_last} = 0;
    void'($urandom(32'hf5fba3d0));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, STCH_OFS_STAT, 32'h0);
    chk("stat_rst", rd, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped_err", er, 32'h1);
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, STCH_OFS_FMT, 32'(fv[i]));
      chk("fmt", fmt_programmed, fe[i]);
    end
    for (int r = 0; r < 2; r++)
    begin
      dev = $urandom_range(15, 1);
      attr = $urandom_range(3, 0);
      apb(1'b1, STCH_OFS_CFG, 32'(attr * 16 + dev));
      apb(1'b0, STCH_OFS_CFG, 32'h0);
      chk("cfg", rd, 32'(attr * 16 + dev));
      for (int i = 0; i < 160; i++)
      begin
        k = $urandom_range(3, 0);
        c = (k == 3) ? 4'($urandom) : (k == 1) ? STCH_CMD_ENABLE : STCH_CMD_DISABLE;
        k = $urandom_range(2, 0);
        a = (k == 0) ? dev[3:0] : (k == 1) ? 4'h0 : 4'($urandom);
        {v, ok} = {$urandom_range(2, 0) != 0, $urandom_range(5, 0) != 0};
        {l, ie, ot} = 3'($urandom);
        hc = $urandom_range(5, 0) == 0 && c != STCH_CMD_ENABLE;
        cl = !v && $urandom_range(5, 0) == 0;
        @(posedge pclk);
        mst_u.send(v, l, c, a, ok);
        clear_cmd <= cl;
        hold_capacitor_pin_low <= hc;
        internal_error <= ie;
        otp_program_enabled_flag <= ot;
        @(negedge pclk);
        check_out();
        model();
      end
      @(posedge pclk);
      mst_u.send(1'b0, 1'b0, 4'h0, 4'h0, 1'b0);
      {clear_cmd, hold_capacitor_pin_low} <= 2'b00;
      @(negedge pclk);
      check_out();
      {v, cl, hc} = 3'b000;
      model();
      @(posedge pclk);
      apb(1'b0, STCH_OFS_STAT, 32'h0);
      chk("stat", rd[1:0], 32'(m_lock * 2 + m_drv));
      apb(1'b0, STCH_OFS_RESP, 32'h0);
      chk("resp_reg", rd, 32'(e_last));
    end
    // two global disables back to back, then a reset in mid-run drops the lockout
    mst_u.send(1'b1, 1'b0, STCH_CMD_DISABLE, STCH_GLOBAL_ADDR, 1'b1);
    repeat (2) @(posedge pclk);
    mst_u.send(1'b0, 1'b0, 4'h0, 4'h0, 1'b0);
    @(negedge pclk);
    chk("lock_pair", selftest_lockout, 32'h1);
    chk("lock_drive", selftest_plate_drive, 32'h0);
    chk("lock_quiet", resp_valid, 32'h0);
    @(posedge pclk);
    presetn <= 1'b0;
    @(negedge pclk);
    chk("lock_rst", selftest_lockout, 32'h0);
    @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("lock_rel", selftest_lockout, 32'h0);
    chk("drive_rel", selftest_plate_drive, 32'h0);
    stop_test();
  end
  initial
  begin
    #50000;
    n_errors++;
    stop_test();
  end
endmodule
